// ### dv/io_ports_props.sv
// Port-level checks for the three-port I/O block
`default_nettype none
module io_ports_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       hresp,
  input wire logic       hreadyout,
  input wire logic       swStandby,
  input wire logic [7:0] port7In,
  input wire logic [7:0] port9In,
  input wire logic [7:0] port7Oe,
  input wire logic [7:0] port9Oe,
  input wire logic [2:0] captureIn,
  input wire logic [2:0] timerExtClkIn,
  input wire logic       byteTimerClearIn,
  input wire logic       byteTimerClkIn,
  input wire logic       serialRxd,
  input wire logic       serialClkIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Assertions, one clock domain
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_no_error:
    assert property (!hresp && hreadyout) else $error("bus answer bad");
  chk_reset_inputs:
    assert property (!$past(rst_n) |-> port7Oe == 8'h00 && port9Oe == 8'h00)
    else $error("pins driven after reset");
  // Skip the first edge after reset, when the flops still hold reset values
  chk_capture_follow:
    assert property ($past(rst_n) |-> captureIn == $past(port7In[3:1]))
    else $error("capture inputs do not follow pins");
  chk_ext_clk_pin:
    assert property ((timerExtClkIn & ~$past(port7In[6:4])) == 3'h0)
    else $error("timer clock high with pin low");
  chk_clear_pin:
    assert property (byteTimerClearIn |-> $past(port7In[3]))
    else $error("byte timer clear without pin");
  chk_tclk_pin:
    assert property (byteTimerClkIn |-> $past(port7In[0]))
    else $error("byte timer clock without pin");
  chk_rxd_pin:
    assert property (!serialRxd |-> !$past(port9In[6]))
    else $error("receive data low with pin high");
  chk_sclk_pin:
    assert property (serialClkIn |-> $past(port9In[7]))
    else $error("serial clock without pin");
  chk_standby_release:
    assert property (swStandby[*3] |-> serialRxd && timerExtClkIn == 3'h0
                     && !byteTimerClearIn)
    else $error("peripherals keep pins in standby");
  cover property (swStandby[*3]);
  cover property (byteTimerClearIn && byteTimerClkIn);
  cover property (serialClkIn && timerExtClkIn[2]);
endmodule
`default_nettype wire

// ### dv/pin_board_model.sv
// Board side of the port pins: chip drivers win, else board sources
`default_nettype none
module pin_board_model (
  input  wire logic [7:0] port7Out,
  input  wire logic [7:0] port7Oe,
  input  wire logic [7:0] port9Out,
  input  wire logic [7:0] port9Oe,
  input  wire logic [7:0] board7,
  input  wire logic [7:0] board9,
  output wire logic [7:0] port7In,
  output wire logic [7:0] port9In
);
  timeunit 1ns;
  timeprecision 1ps;
  // Per-bit resolve; board sources are weak and give way to the chip
  assign port7In = (port7Oe & port7Out) | (~port7Oe & board7);
  assign port9In = (port9Oe & port9Out) | (~port9Oe & board9);
endmodule
`default_nettype wire

// ### dv/test_io_ports_seven_to_nine.sv
// Self-checking bench for the three-port I/O block
`default_nettype none
`include "io_ports_map.vh"
module test_io_ports_seven_to_nine;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        swStandby = 1'b0, serialTxd = 1'b0, serialClkOut = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, timerMatchA = 2'h0;
  logic [2:0]  hsize = 3'h2, timerMatchB = 3'h0, pwmOut = 3'h0;
  logic [7:0]  board7 = 8'h00, board9 = 8'hC3, port8In = 8'h5A;
  logic        hreadyout, hresp, byteTimerClearIn, byteTimerClkIn;
  logic        serialRxd, serialClkIn;
  logic [2:0]  timerExtClkIn, captureIn;
  logic [7:0]  port7In, port7Out, port7Oe, port9In, port9Out, port9Oe;
  int          numErrors = 0, checkCount = 0;
  always #2 clk = ~clk;
  io_ports_seven_to_nine dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .swStandby(swStandby),
    .timerMatchB(timerMatchB), .timerMatchA(timerMatchA), .pwmOut(pwmOut),
    .serialTxd(serialTxd), .serialClkOut(serialClkOut),
    .timerExtClkIn(timerExtClkIn), .captureIn(captureIn),
    .byteTimerClearIn(byteTimerClearIn), .byteTimerClkIn(byteTimerClkIn),
    .serialRxd(serialRxd), .serialClkIn(serialClkIn), .port7In(port7In),
    .port7Out(port7Out), .port7Oe(port7Oe), .port8In(port8In),
    .port9In(port9In), .port9Out(port9Out), .port9Oe(port9Oe));
  pin_board_model board (.port7Out(port7Out), .port7Oe(port7Oe),
    .port9Out(port9Out), .port9Oe(port9Oe), .board7(board7),
    .board9(board9), .port7In(port7In), .port9In(port9In));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single transfer; waits on hready only, the watchdog cuts hangs
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Pins follow registers one edge late; margin for the pin loop-back
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic finishTest;
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic resetValues;
    bus(1'b0, `IDX_PORT9_DIRECTION, 32'h0);
    check("dir9 read", rd, 32'hFF);
    bus(1'b0, `IDX_PORT9_OUTPUT_LATCH, 32'h0);
    check("latch9 inputs", rd, {24'h0, board9});
    bus(1'b0, `IDX_PORT8_INPUT_PINS, 32'h0);
    check("port8 read", rd, {24'h0, port8In});
    bus(1'b0, 16'h1234, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("oe9 reset", {24'h0, port9Oe}, 32'h0);
  endtask
  task automatic gpioPort9;
    bus(1'b1, `IDX_PORT9_DIRECTION, 32'h0F);
    bus(1'b1, `IDX_PORT9_OUTPUT_LATCH, 32'hA5);
    settle;
    check("oe9", {24'h0, port9Oe}, 32'h0F);
    check("out9", {28'h0, port9Out[3:0]}, 32'h5);
    bus(1'b0, `IDX_PORT9_OUTPUT_LATCH, 32'h0);
    check("latch9 mixed", rd, {24'h0, board9[7:4], 4'h5});
  endtask
  // Shared pins claimed at once except port 7 bits 6 and 5; board holds the receive pin low
  task automatic peripherals;
    timerMatchB <= 3'h5;
    timerMatchA <= 2'h1;
    pwmOut <= 3'h2;
    serialTxd <= 1'b1;
    board7 <= 8'hED;
    board9 <= 8'h83;
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h1C);
    bus(1'b1, `IDX_PERIPH_CTRL, 32'h002DF0F9);
    settle;
    check("oe9 shared", {24'h0, port9Oe}, 32'h3F);
    check("tx pin", {31'h0, port9Out[5]}, 32'h1);
    check("pwm pins", {29'h0, port9Out[4:2]}, 32'h2);
    check("match-A", {30'h0, port9Out[1:0]}, 32'h1);
    check("match-B", {30'h0, port7Oe[4], port7Out[4]}, 32'h3);
    check("capture", {29'h0, captureIn}, 32'h6);
    check("ext clk", {29'h0, timerExtClkIn}, 32'h4);
    check("byte clr", {31'h0, byteTimerClearIn}, 32'h1);
    check("byte clk", {31'h0, byteTimerClkIn}, 32'h1);
    check("rxd", {31'h0, serialRxd}, 32'h0);
    check("sclk", {31'h0, serialClkIn}, 32'h1);
    bus(1'b0, `IDX_PORT8_INPUT_PINS, 32'h0);
    check("adc pin", rd, {24'h0, port8In | 8'h04});
  endtask
  task automatic standby;
    swStandby <= 1'b1;
    repeat (3) @(posedge clk);
    swStandby <= 1'b0;
    settle;
    check("dir kept", {24'h0, port9Oe}, 32'h0F);
    check("latch back", {28'h0, port9Out[3:0]}, 32'h5);
    check("match-B off", {31'h0, port7Oe[4]}, 32'h0);
  endtask
  // Pin 7 in sync out, async out, GPIO and sync external-in modes, then receive overriding a set direction
  task automatic serialModes;
    @(posedge clk);
    serialClkOut <= 1'b1;
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h01);
    settle;
    check("sck sync out", {30'h0, port9Oe[7], port9Out[7]}, 32'h3);
    check("sck in idle", {31'h0, serialClkIn}, 32'h0);
    @(posedge clk);
    serialClkOut <= 1'b0;
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h02);
    settle;
    check("sck async out", {30'h0, port9Oe[7], port9Out[7]}, 32'h2);
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h00);
    settle;
    check("sck gpio", {30'h0, port9Oe[7], port9Out[7]}, 32'h1);
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h05);
    settle;
    check("sck ext in", {30'h0, port9Oe[7], serialClkIn}, 32'h1);
    bus(1'b1, `IDX_PORT9_DIRECTION, 32'hFF);
    bus(1'b1, `IDX_SERIAL_CTRL, 32'h08);
    settle;
    check("rx pin input", {24'h0, port9Oe}, 32'hBF);
    check("rxd low", {31'h0, serialRxd}, 32'h0);
  endtask
  // Reset again in mid-run: direction clears, pins fall back to inputs
  task automatic midReset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    check("oe9 after reset", {24'h0, port9Oe}, 32'h0);
    check("rxd after reset", {31'h0, serialRxd}, 32'h1);
    bus(1'b0, `IDX_PORT9_OUTPUT_LATCH, 32'h0);
    check("latch9 after reset", rd, {24'h0, board9});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    resetValues;
    gpioPort9;
    peripherals;
    standby;
    serialModes;
    midReset;
    finishTest;
  end
  // Watchdog: the whole run needs under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    numErrors++;
    finishTest;
  end
endmodule
bind io_ports_seven_to_nine io_ports_props chk (.clk(clk), .rst_n(rst_n),
  .hresp(hresp), .hreadyout(hreadyout), .swStandby(swStandby),
  .port7In(port7In), .port9In(port9In), .port7Oe(port7Oe),
  .port9Oe(port9Oe), .captureIn(captureIn), .timerExtClkIn(timerExtClkIn),
  .byteTimerClearIn(byteTimerClearIn), .byteTimerClkIn(byteTimerClkIn),
  .serialRxd(serialRxd), .serialClkIn(serialClkIn));
`default_nettype wire

// ### verilog/io_ports_map.vh
// Register map and field constants for the three-port I/O block
`ifndef IO_PORTS_MAP_VH
`define IO_PORTS_MAP_VH
// Register byte addresses, four times the printed index
`define ADDR_PORT8_INPUT_PINS   18'h3FE3C
`define ADDR_PORT9_DIRECTION    18'h3FFF8
`define ADDR_PORT9_OUTPUT_LATCH 18'h3FFFC
// Printed register indexes; byte address is four times the index
`define IDX_PORT8_INPUT_PINS   16'hFF8F
`define IDX_PORT9_DIRECTION    16'hFFFE
`define IDX_PORT9_OUTPUT_LATCH 16'hFFFF
// Own registers, word offsets (index form, times four on the bus)
`define IDX_PORT7_DIRECTION    16'hFF8C
`define IDX_PORT7_OUTPUT_LATCH 16'hFF8E
`define IDX_PERIPH_CTRL        16'hFF80
`define IDX_SERIAL_CTRL        16'hFF81
// Reset values
`define RST_PORT7_DIRECTION    8'h00
`define RST_PORT7_OUTPUT_LATCH 8'h00
`define RST_PORT9_DIRECTION    8'h00
`define RST_PORT9_OUTPUT_LATCH 8'h00
`define RST_PERIPH_CTRL        32'h0000_0000
`define RST_SERIAL_CTRL        8'h00
// Value seen when reading the write-only direction registers
`define DIR_READBACK           8'hFF
// Peripheral control word fields
`define PC_CMP_B_LSB           0
`define PC_CMP_A_LSB           3
`define PC_PWM_LSB             5
`define PC_FRC_CKS_LSB         8
`define PC_BYTE_CCLR_LSB       14
`define PC_BYTE_CKS_LSB        16
`define PC_ADC_ACTIVE          19
`define PC_ADC_CHAN_LSB        20
// Serial control fields
`define SC_SYNC_MODE           0
`define SC_CLK_EN_LO           1
`define SC_CLK_EN_HI           2
`define SC_RX_ON               3
`define SC_TX_ON               4
// Byte timer external-clock select codes
`define BYTE_CKS_EXT_RISE      3'h5
`endif

// ### verilog/io_ports_seven_to_nine.v
// Three 8-bit I/O ports with peripheral pin sharing, AHB-Lite slave
`default_nettype none
`include "io_ports_map.vh"
// Operation
// - Pins 6..4 drive timer match-B when enabled
// - Pins 6..4 feed timer external clock
// - Pin 3 is capture and byte-timer clear
// - Pins 3..1 always feed capture inputs
// - Pin 0 may clock the byte timer
// - Input-only port, no direction register
// - Converting analogue pin reads as one
// - Direction bit one means output
// - Direction register reads back all ones
// - Reset clears direction to inputs
// - Software standby keeps direction register
// - Standby returns peripheral pins to GPIO
// - Data read: latch if output, else pin
// - Pin 7 serial clock per mode bits
// - Pin 6 becomes receive input when enabled
// - Pin 5 drives transmit when enabled
// - Function selection independent of mode pins
// - Pins 4..2 drive PWM when enabled
// - Pins 1..0 drive timer match-A outputs
module io_ports_seven_to_nine (
  input  wire        clk,
  input  wire        rst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Standby entry resets peripheral claims
  input  wire        swStandby,
  // Peripheral signals
  input  wire [2:0]  timerMatchB,
  input  wire [1:0]  timerMatchA,
  input  wire [2:0]  pwmOut,
  input  wire        serialTxd,
  input  wire        serialClkOut,
  output reg  [2:0]  timerExtClkIn,
  output reg  [2:0]  captureIn,
  output reg         byteTimerClearIn,
  output reg         byteTimerClkIn,
  output reg         serialRxd,
  output reg         serialClkIn,
  // Pins
  input  wire [7:0]  port7In,
  output reg  [7:0]  port7Out,
  output reg  [7:0]  port7Oe,
  input  wire [7:0]  port8In,
  input  wire [7:0]  port9In,
  output reg  [7:0]  port9Out,
  output reg  [7:0]  port9Oe
);
  //--------------------------------------------------------------
  // Pin map, port 7
  //--------------------------------------------------------------
  // Bit 7: plain GPIO here; its compare output is owned elsewhere
  // Bit 6: match-B of channel 3, else GPIO plus channel 3 clock
  // Bit 5: match-B of channel 2, else GPIO plus channel 2 clock
  // Bit 4: match-B of channel 1, else GPIO plus channel 1 clock
  // Bit 3: GPIO, channel 3 capture and byte-timer clear
  // Bit 2: GPIO and channel 2 capture
  // Bit 1: GPIO and channel 1 capture
  // Bit 0: GPIO and byte-timer external clock
  // Input functions listen to the pin and never take it over
  //--------------------------------------------------------------
  // Pin map, port 8
  //--------------------------------------------------------------
  // All bits input only; no direction register exists
  // The channel under conversion reads as one, the others live
  // Converter busy flag and channel come from the control word
  //--------------------------------------------------------------
  // Pin map, port 9
  //--------------------------------------------------------------
  // Bit 7: serial clock, out or in by the sync-mode and clock-enable bits
  // Bit 6: receive data while the receiver is on
  // Bit 5: transmit data while the transmitter is on
  // Bits 4..2: PWM channels 3..1
  // Bits 1..0: match-A of channels 3 and 2
  // Receive and external clock mask the direction bit, so a
  // stale output setting cannot fight a board driver on those pins
  //--------------------------------------------------------------
  // Register map (word index; byte address is four times it)
  //--------------------------------------------------------------
  // Port 8 pins:      read only, live levels
  // Port 9 direction: write only, reads all ones
  // Port 9 latch:     latch on outputs, pin level on inputs
  // Port 7 direction: write only, reads all ones
  // Port 7 latch:     same read rule as port 9
  // Peripheral ctl:   stand-in for timer and converter bits
  // Serial ctl:       stand-in for serial mode and enable bits
  // Limitation: the stand-ins hold bits the real peripherals own;
  // a full system would wire those bits from the owning modules
  //--------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------
  // Bus has zero wait states; read data registered at address phase
  // A write lands at the edge that ends its data phase
  // Pins and peripheral inputs follow one clock after that
  // Trade-off: one cycle of pin latency for flop-driven outputs
  // Standby clears the stand-ins only, never the port registers
  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  reg  [7:0]  p7Dir_q;
  reg  [7:0]  p7Latch_q;
  reg  [7:0]  p9Dir_q;
  reg  [7:0]  p9Latch_q;
  reg  [31:0] periphCtl_q;
  reg  [7:0]  serialCtl_q;
  reg         wrPend_q;
  reg  [15:0] wrIdx_q;
  reg  [15:0] rdIdx_d;

  // Decoded control fields
  wire [2:0] cmpBOn   = periphCtl_q[`PC_CMP_B_LSB +: 3];
  wire [1:0] cmpAOn   = periphCtl_q[`PC_CMP_A_LSB +: 2];
  wire [2:0] pwmOn    = periphCtl_q[`PC_PWM_LSB +: 3];
  wire [5:0] frcCks   = periphCtl_q[`PC_FRC_CKS_LSB +: 6];
  wire [1:0] byteClr  = periphCtl_q[`PC_BYTE_CCLR_LSB +: 2];
  wire [2:0] byteCks  = periphCtl_q[`PC_BYTE_CKS_LSB +: 3];
  wire       adcBusy  = periphCtl_q[`PC_ADC_ACTIVE];
  wire [2:0] adcChan  = periphCtl_q[`PC_ADC_CHAN_LSB +: 3];
  wire       syncMode = serialCtl_q[`SC_SYNC_MODE];
  wire       clkEnLo  = serialCtl_q[`SC_CLK_EN_LO];
  wire       clkEnHi  = serialCtl_q[`SC_CLK_EN_HI];
  wire       rxOn     = serialCtl_q[`SC_RX_ON];
  wire       txOn     = serialCtl_q[`SC_TX_ON];

  //--------------------------------------------------------------
  // Pin function selection (no mode pin enters here)
  //--------------------------------------------------------------
  wire [7:0] p7PerOn;
  wire [7:0] p7PerDat;
  wire [7:0] p9PerOn;
  wire [7:0] p9PerDat;
  wire [7:0] p7OeD;
  wire [7:0] p7OutD;
  wire [7:0] p9OeD;
  wire [7:0] p9OutD;
  wire       sckOut;
  wire       sckIn;

  // Async: 01 internal out, 1x external in; sync: 0x out, 1x in
  assign sckIn  = clkEnHi;
  assign sckOut = !clkEnHi && (syncMode || clkEnLo);

  // Port 7: bit 7 match-A of channel 1 is outside this block
  assign p7PerOn  = {1'b0, cmpBOn, 4'h0};
  assign p7PerDat = {1'b0, timerMatchB, 4'h0};
  // Port 9: clock out, txd, pwm 3..1, match-A 3..2; rxd takes nothing
  assign p9PerOn  = {sckOut, 1'b0, txOn, pwmOn, cmpAOn};
  assign p9PerDat = {serialClkOut, 1'b0, serialTxd, pwmOut, timerMatchA};

  // Receive enable and external clock force the pin to an input
  wire [7:0] p9Force = {sckIn, rxOn, 6'h00};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gMux
      pin_mux_cell u7 (
        .periphOn   (p7PerOn[g]),
        .periphData (p7PerDat[g]),
        .dirBit     (p7Dir_q[g]),
        .latchBit   (p7Latch_q[g]),
        .pinOe      (p7OeD[g]),
        .pinData    (p7OutD[g])
      );
      pin_mux_cell u9 (
        .periphOn   (p9PerOn[g]),
        .periphData (p9PerDat[g]),
        .dirBit     (p9Dir_q[g] & ~p9Force[g]),
        .latchBit   (p9Latch_q[g]),
        .pinOe      (p9OeD[g]),
        .pinData    (p9OutD[g])
      );
    end
  endgenerate

  // Pin outputs and peripheral inputs, registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port7Out         <= 8'h00;
      port7Oe          <= 8'h00;
      port9Out         <= 8'h00;
      port9Oe          <= 8'h00;
      timerExtClkIn    <= 3'h0;
      captureIn        <= 3'h0;
      byteTimerClearIn <= 1'b0;
      byteTimerClkIn   <= 1'b0;
      serialRxd        <= 1'b1;
      serialClkIn      <= 1'b0;
    end else begin
      port7Out <= p7OutD;
      port7Oe  <= p7OeD;
      port9Out <= p9OutD;
      port9Oe  <= p9OeD;
      // External clock only when both select bits of a channel are 1
      timerExtClkIn[0] <= (&frcCks[1:0]) & ~cmpBOn[0] & port7In[4];
      timerExtClkIn[1] <= (&frcCks[3:2]) & ~cmpBOn[1] & port7In[5];
      timerExtClkIn[2] <= (&frcCks[5:4]) & ~cmpBOn[2] & port7In[6];
      captureIn        <= port7In[3:1];
      byteTimerClearIn <= (&byteClr) & port7In[3];
      byteTimerClkIn   <= (byteCks >= `BYTE_CKS_EXT_RISE)
                          & port7In[0];
      serialRxd        <= rxOn ? port9In[6] : 1'b1;
      serialClkIn      <= sckIn & port9In[7];
    end
  end

  //--------------------------------------------------------------
  // AHB-Lite slave
  //--------------------------------------------------------------
  // Index = byte address / 4 with bits 15..14 forced to one; printed offsets live in the low bits
  wire        xfer    = hsel && hready && htrans[1];
  wire [15:0] reqIdx  = {2'b00, haddr[15:2]} | 16'hC000;
  wire [7:0]  p8Read;
  wire [7:0]  adcMask;

  // Pin under conversion always reads 1
  assign adcMask = adcBusy ? (8'h01 << adcChan) : 8'h00;
  assign p8Read  = port8In | adcMask;

  // Read mux, decoded in the address phase
  reg [31:0] rdData_d;
  always @* begin
    rdIdx_d  = reqIdx;
    rdData_d = 32'h0000_0000;
    case (rdIdx_d)
      `IDX_PORT8_INPUT_PINS:   rdData_d = {24'h0, p8Read};
      `IDX_PORT9_DIRECTION:    rdData_d = {24'h0, `DIR_READBACK};
      `IDX_PORT9_OUTPUT_LATCH:
        rdData_d = {24'h0, (p9Latch_q & p9Dir_q)
                           | (port9In & ~p9Dir_q)};
      `IDX_PORT7_DIRECTION:    rdData_d = {24'h0, `DIR_READBACK};
      `IDX_PORT7_OUTPUT_LATCH:
        rdData_d = {24'h0, (p7Latch_q & p7Dir_q)
                           | (port7In & ~p7Dir_q)};
      `IDX_PERIPH_CTRL:        rdData_d = periphCtl_q;
      `IDX_SERIAL_CTRL:        rdData_d = {24'h0, serialCtl_q};
      default:                 rdData_d = 32'h0000_0000;
    endcase
  end

  // Zero wait states; unmapped addresses read zero, writes dropped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= 1'b0;
      wrIdx_q   <= 16'h0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_q  <= xfer && hwrite;
      if (xfer) begin
        wrIdx_q <= reqIdx;
      end
      if (xfer && !hwrite) begin
        hrdata <= rdData_d;
      end
    end
  end

  //--------------------------------------------------------------
  // Register writes in the data phase
  //--------------------------------------------------------------
  // Direction registers survive standby; only reset clears them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p7Dir_q     <= `RST_PORT7_DIRECTION;
      p7Latch_q   <= `RST_PORT7_OUTPUT_LATCH;
      p9Dir_q     <= `RST_PORT9_DIRECTION;
      p9Latch_q   <= `RST_PORT9_OUTPUT_LATCH;
      periphCtl_q <= `RST_PERIPH_CTRL;
      serialCtl_q <= `RST_SERIAL_CTRL;
    end else begin
      if (wrPend_q) begin
        case (wrIdx_q)
          `IDX_PORT9_DIRECTION:    p9Dir_q     <= hwdata[7:0];
          `IDX_PORT9_OUTPUT_LATCH: p9Latch_q   <= hwdata[7:0];
          `IDX_PORT7_DIRECTION:    p7Dir_q     <= hwdata[7:0];
          `IDX_PORT7_OUTPUT_LATCH: p7Latch_q   <= hwdata[7:0];
          `IDX_PERIPH_CTRL:        periphCtl_q <= hwdata;
          `IDX_SERIAL_CTRL:        serialCtl_q <= hwdata[7:0];
          default:                 p9Dir_q     <= p9Dir_q;
        endcase
      end
      // Standby wins: peripherals reinitialised, pins revert to GPIO
      if (swStandby) begin
        periphCtl_q <= `RST_PERIPH_CTRL;
        serialCtl_q <= `RST_SERIAL_CTRL;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/pin_mux_cell.v
// One pin's function multiplexer: peripheral over port latch
`default_nettype none
module pin_mux_cell (
  input  wire periphOn,
  input  wire periphData,
  input  wire dirBit,
  input  wire latchBit,
  output wire pinOe,
  output wire pinData
);
  // Peripheral claim forces the pin out; latch is untouched meanwhile
  assign pinOe   = periphOn | dirBit;
  assign pinData = periphOn ? periphData : latchBit;
endmodule
`default_nettype wire
